//--- rtl/period_measure_defines.vh
/*
 * constants for the input period / pwm measurement sub-block:
 * mode codes, control field positions, enable bits, reset values.
 * assumes inclusion by bare name from the design files.
 */
`ifndef PERIOD_MEASURE_DEFINES_VH
`define PERIOD_MEASURE_DEFINES_VH

// mode control field layout (8-bit value)
`define MODE_EDGE_SEL_LSB 0
`define MODE_EDGE_SEL_MSB 1
`define MODE_FUNC_LSB 2
`define MODE_FUNC_MSB 3
`define MODE_FUNC_W 2
`define MODE_CLK_BUS_LSB 4
`define MODE_CLK_BUS_MSB 5

// function codes inside the mode field
`define FUNC_HIGH_LOW 2'h2
`define FUNC_PWM_WAVE 2'h0

// level / edge select codes
`define SEL_RISE_HIGH 2'h1
`define SEL_FALL_LOW 2'h2
`define SEL_BOTH 2'h3

// level select in high/low mode: 2'h2 measures high, 2'h1 measures low
`define SEL_LEVEL_LOW 2'h1

// pwm waveform measurement enable bit in mode field
`define MODE_PWM_BIT 4

// unit enable register bits
`define UNIT_EN_TIMER_BIT 6
`define UNIT_EN_PRESC_BIT 0

// interrupt enable / status / clear bit for capture
`define CAPTURE_FLAG_BIT 0

// reset values
`define RST_PRESC_RATIO 16'h0000
`define RST_COUNT 32'h0000_0000

`endif

//--- rtl/clock_bus_prescaler.v
/*
 * prescaler producing one clock-bus tick every ratio+1 clocks.
 * assumes a synchronous active-high reset and a single clock.
 */
`timescale 1ns/1ps
`include "period_measure_defines.vh"

module clock_bus_prescaler #(
    parameter RATIO_W = 16
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // control
    input wire enable,
    input wire [RATIO_W-1:0] ratio,
    // tick out
    output reg tick
);

    reg [RATIO_W-1:0] div_reg;

    // [RQ5] divide by ratio plus one
    always @(posedge clk)
    begin
        if (rst || !enable)
        begin
            div_reg <= {RATIO_W{1'b0}};
            tick <= 1'b0;
        end
        else if (div_reg >= ratio)
        begin
            div_reg <= {RATIO_W{1'b0}};
            tick <= 1'b1;
        end
        else
        begin
            div_reg <= div_reg + 1'b1;
            tick <= 1'b0;
        end
    end

endmodule

//--- rtl/input_period_pwm_measure.v
/*
 * input high/low period and pwm waveform measurement sub-block with its
 * prescaler, run, enable, status and capture registers as plain ports.
 * assumes measure_input_pin is synchronous to clk and already filtered;
 * clear strobes are one-cycle pulses from software logic; run is a level held for the whole measurement.
 */
// Overview of operation
// [RQ1] high/low mode: time counter ticks only while pin is at chosen level
// [RQ2] event counter counts each valid input event during measurement
// [RQ3] high/low mode: reaching pulse count setting raises capture interrupt
// [RQ4] mode value 0x0A picks clock bus, high/low mode, high level
// [RQ5] prescaler divides clock by ratio field plus one
// [RQ6] unit enable holds separate timer and prescaler enable bits
// [RQ7] mode value 0x11 picks bus 0, pwm mode, rising edge
// [RQ8] pwm mode: separate edge counter counts input edges
// [RQ9] pwm completion puts off-duty total into capture data register
// [RQ10] pwm completion puts cycle count into cycle capture register
// [RQ11] off-duty counts only while input off; cycle counts from start
// [RQ12] pwm mode: pulse count setting gives edges before capture
// [RQ13] interrupt enable bit gates the capture interrupt request
// [RQ14] run register bit 0 starts counting in sub-block 0
// [RQ15] writing one to clear bit clears the capture flag
// [RQ16] high/low mode capture data receives summed level time
// [RQ17] status register holds capture flag set on completion
// [RQ18] flag sticks until cleared; request while flag and enable set
// [RQ19] counters start from zero and rearm after capture
`timescale 1ns/1ps
`include "period_measure_defines.vh"

module input_period_pwm_measure #(
    parameter CNT_W = 32,
    parameter SET_W = 16,
    parameter RATIO_W = 16
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // measured input
    input wire measure_input_pin,
    // configuration
    input wire [7:0] unit_enable_reg,
    input wire [RATIO_W-1:0] prescaler_ratio_reg,
    input wire [7:0] subblock_mode_ctrl,
    input wire [SET_W-1:0] pulse_count_setting,
    input wire [7:0] irq_enable_reg,
    input wire [7:0] subblock_run_reg,
    input wire [7:0] flag_clear_reg,
    // status and results
    output wire [7:0] flag_status_reg,
    output reg [CNT_W-1:0] level_time_counter,
    output reg [CNT_W-1:0] valid_event_counter,
    output reg [CNT_W-1:0] input_edge_counter,
    output reg [CNT_W-1:0] cycle_count,
    output reg [CNT_W-1:0] capture_data_reg,
    output reg [CNT_W-1:0] cycle_capture_reg,
    output wire capture_irq
);

    localparam ST_IDLE = 2'b01;
    localparam ST_RUN = 2'b10;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg pin_d_reg;
    reg capture_done_flag;
    wire timer_en;
    wire presc_en;
    wire run;
    wire tick;
    wire rise;
    wire fall;
    wire edge_hit;
    wire level_hit;
    wire pwm_mode;
    wire hl_mode;
    wire [1:0] sel;
    wire done;
    wire [CNT_W-1:0] target;

    // [RQ6] independent timer and prescaler enables
    assign timer_en = unit_enable_reg[`UNIT_EN_TIMER_BIT];
    assign presc_en = unit_enable_reg[`UNIT_EN_PRESC_BIT];
    // [RQ14] run bit 0 starts sub-block 0
    assign run = subblock_run_reg[0] & timer_en;

    // [RQ5] clock bus tick generator
    clock_bus_prescaler #(
        .RATIO_W(RATIO_W)
    ) u_presc (
        .clk(clk),
        .rst(rst),
        .enable(presc_en),
        .ratio(prescaler_ratio_reg),
        .tick(tick)
    );

    // [RQ4] [RQ7] mode field decode
    assign sel = subblock_mode_ctrl[`MODE_EDGE_SEL_MSB:`MODE_EDGE_SEL_LSB];
    assign pwm_mode = subblock_mode_ctrl[`MODE_PWM_BIT];
    assign hl_mode = !pwm_mode &&
        (subblock_mode_ctrl[`MODE_FUNC_MSB:`MODE_FUNC_LSB] == `FUNC_HIGH_LOW);

    // input edge detection
    always @(posedge clk)
    begin
        if (rst)
            pin_d_reg <= 1'b0;
        else
            pin_d_reg <= measure_input_pin;
    end

    assign rise = measure_input_pin & ~pin_d_reg;
    assign fall = ~measure_input_pin & pin_d_reg;

    // [RQ2] valid event: edge of the selected kind
    assign edge_hit = (sel == `SEL_RISE_HIGH) ? rise :
                      (sel == `SEL_FALL_LOW) ? fall :
                      (sel == `SEL_BOTH) ? (rise | fall) : 1'b0;

    // [RQ1] [RQ4] level match; mode 0x0A measures the high level
    assign level_hit = (sel == `SEL_LEVEL_LOW) ? ~measure_input_pin
                                               : measure_input_pin;

    // [RQ3] [RQ12] compare with pulse count setting
    assign target = {{(CNT_W-SET_W){1'b0}}, pulse_count_setting};
    assign done = (state_reg == ST_RUN) && edge_hit &&
        (pulse_count_setting != {SET_W{1'b0}}) &&
        ((pwm_mode ? input_edge_counter : valid_event_counter) + 1'b1
            == target);

    // state sequencing
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (run)
                    state_next = ST_RUN;
            ST_RUN:
                if (!run)
                    state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always @(posedge clk)
    begin
        if (rst)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // counters, cleared at start and after capture
    always @(posedge clk)
    begin
        if (rst || state_reg == ST_IDLE)
        begin
            // [RQ19] start from zero
            level_time_counter <= `RST_COUNT;
            valid_event_counter <= `RST_COUNT;
            input_edge_counter <= `RST_COUNT;
            cycle_count <= `RST_COUNT;
        end
        else if (done)
        begin
            // [RQ19] rearm for the next measurement
            level_time_counter <= `RST_COUNT;
            valid_event_counter <= `RST_COUNT;
            input_edge_counter <= `RST_COUNT;
            cycle_count <= `RST_COUNT;
        end
        else
        begin
            // [RQ1] level time in high/low mode
            if (hl_mode && tick && level_hit)
                level_time_counter <= level_time_counter + 1'b1;
            // [RQ11] off-duty: pwm off is low input
            else if (pwm_mode && tick && !measure_input_pin)
                level_time_counter <= level_time_counter + 1'b1;
            // [RQ11] cycle counter runs from start
            if (pwm_mode && tick)
                cycle_count <= cycle_count + 1'b1;
            // [RQ2] count valid events
            if (edge_hit)
                valid_event_counter <= valid_event_counter + 1'b1;
            // [RQ8] separate edge counter in pwm mode
            if (pwm_mode && edge_hit)
                input_edge_counter <= input_edge_counter + 1'b1;
        end
    end

    // capture registers loaded at completion
    always @(posedge clk)
    begin
        if (rst)
        begin
            capture_data_reg <= `RST_COUNT;
            cycle_capture_reg <= `RST_COUNT;
        end
        else if (done)
        begin
            // [RQ16] [RQ9] level time or off-duty total
            capture_data_reg <= level_time_counter +
                {{(CNT_W-1){1'b0}}, (tick &
                 (pwm_mode ? ~measure_input_pin : level_hit))};
            // [RQ10] cycle count since start
            if (pwm_mode)
                cycle_capture_reg <= cycle_count +
                    {{(CNT_W-1){1'b0}}, tick};
        end
    end

    // [RQ17] [RQ18] [RQ15] sticky flag, set wins over clear
    always @(posedge clk)
    begin
        if (rst)
            capture_done_flag <= 1'b0;
        else if (done)
            capture_done_flag <= 1'b1;
        else if (flag_clear_reg[`CAPTURE_FLAG_BIT])
            capture_done_flag <= 1'b0;
    end

    assign flag_status_reg = {7'h00, capture_done_flag};
    // [RQ13] [RQ18] request gated by enable
    assign capture_irq = capture_done_flag &
        irq_enable_reg[`CAPTURE_FLAG_BIT];

endmodule

//--- tb/period_measure_checker.sv
/* port assertions for the measurement sub-block.
   assumes one clock and a bind onto the design top. */
`timescale 1ns/1ps
module period_measure_checker #(
    parameter CNT_W = 32
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // controls
    input wire measure_input_pin,
    input wire [7:0] subblock_mode_ctrl,
    input wire [7:0] irq_enable_reg,
    input wire [7:0] subblock_run_reg,
    input wire [7:0] flag_clear_reg,
    // results
    input wire [7:0] flag_status_reg,
    input wire [CNT_W-1:0] level_time_counter,
    input wire [CNT_W-1:0] input_edge_counter,
    input wire [CNT_W-1:0] cycle_count,
    input wire capture_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_irq_gate: assert property (capture_irq ==
        (flag_status_reg[0] && irq_enable_reg[0])) else $error("irq gate");
    a_flag_sticks: assert property (
        flag_status_reg[0] && !flag_clear_reg[0] |=> flag_status_reg[0])
        else $error("flag dropped");
    a_status_spare: assert property (flag_status_reg[7:1] == 7'h00)
        else $error("spare status bits set");
    a_level_hold: assert property (
        subblock_mode_ctrl == 8'h0A && !measure_input_pin |=>
        level_time_counter == 0 || $stable(level_time_counter))
        else $error("level time moved on low pin");
    a_offduty_hold: assert property (
        subblock_mode_ctrl[4] && measure_input_pin |=>
        level_time_counter == 0 || $stable(level_time_counter))
        else $error("off-duty moved on high pin");
    a_capture_zero: assert property ($rose(flag_status_reg[0]) |->
        level_time_counter == 0 && cycle_count == 0)
        else $error("counters not rearmed");
    a_idle_clear: assert property (!subblock_run_reg[0] ##1
        !subblock_run_reg[0] |=>
        level_time_counter == 0 && cycle_count == 0)
        else $error("counters alive while idle");
    a_edge_step: assert property ($changed(input_edge_counter) |->
        input_edge_counter == 0 ||
        input_edge_counter == $past(input_edge_counter) + 1)
        else $error("edge counter jumped");
endmodule
bind input_period_pwm_measure period_measure_checker #(.CNT_W(CNT_W))
    period_measure_checker_i (.clk, .rst, .measure_input_pin,
    .subblock_mode_ctrl, .irq_enable_reg, .subblock_run_reg,
    .flag_clear_reg, .flag_status_reg, .level_time_counter,
    .input_edge_counter, .cycle_count, .capture_irq);

//--- tb/pulse_source.sv
/* external pulse source: low phase first, then high, repeating.
   assumes control inputs change on the falling edge. */
`timescale 1ns/1ps
module pulse_source (
    // clock and control
    input wire clk,
    input wire go,
    input wire idle_lvl,
    input wire [7:0] lo_len,
    input wire [7:0] hi_len,
    // waveform
    output logic pin
);
    logic act;
    logic [7:0] cnt;
    // waveform steps on the falling edge
    always @(negedge clk)
    begin
        if (!go)
        begin
            act <= 1'b0;
            pin <= idle_lvl;
        end
        else if (!act || (pin && cnt == hi_len))
        begin
            act <= 1'b1;
            pin <= 1'b0;
            cnt <= 8'h01;
        end
        else if (!pin && cnt == lo_len)
        begin
            pin <= 1'b1;
            cnt <= 8'h01;
        end
        else
            cnt <= cnt + 8'h01;
    end
endmodule

//--- tb/input_period_pwm_measure_tb_top.sv
/* self-checking bench: high/low, pwm and prescaler scenarios.
   assumes the pulse source model and the bound checker. */
`timescale 1ns/1ps
module input_period_pwm_measure_tb_top;
    localparam int LO = 3;
    localparam int HI = 4;
    logic clk, rst, go, idle_lvl, pin, irq;
    logic [7:0] unit_en, mode, irq_en, run, clr, flags;
    logic [15:0] ratio, setting;
    logic [31:0] lvl, cap, cyc, evt, edg, ccnt;
    int failures, num_checks, cycles;
    input_period_pwm_measure input_period_pwm_measure_i (
        .clk(clk), .rst(rst), .measure_input_pin(pin),
        .unit_enable_reg(unit_en), .prescaler_ratio_reg(ratio),
        .subblock_mode_ctrl(mode), .pulse_count_setting(setting),
        .irq_enable_reg(irq_en), .subblock_run_reg(run),
        .flag_clear_reg(clr), .flag_status_reg(flags),
        .level_time_counter(lvl), .valid_event_counter(evt),
        .input_edge_counter(edg), .cycle_count(ccnt),
        .capture_data_reg(cap),
        .cycle_capture_reg(cyc), .capture_irq(irq));
    pulse_source pulse_source_i (.clk(clk), .go(go), .idle_lvl(idle_lvl),
        .lo_len(8'(LO)), .hi_len(8'(HI)), .pin(pin));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wait_flag();
        int n;
        n = 0;
        while (flags[0] !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        check(32'(n < 200), 32'h0000_0001);
    endtask
    // five high pulses summed, irq gating, flag clear
    task automatic t_high_low();
        mode <= 8'h0A;
        setting <= 16'h0005;
        run <= 8'h01;
        go <= 1'b1;
        wait_flag();
        check(cap, 32'(5 * HI));
        check(evt, 32'h0000_0000);
        check(32'(irq), 32'h0000_0001);
        irq_en <= 8'h00;
        @(negedge clk);
        check(32'(irq), 32'h0000_0000);
        clr <= 8'h01;
        @(negedge clk);
        clr <= 8'h00;
        run <= 8'h00;
        go <= 1'b0;
        idle_lvl <= 1'b1;
        check(32'(flags[0]), 32'h0000_0000);
    endtask
    // six pwm periods: off-duty and cycle capture
    task automatic t_pwm();
        repeat (2) @(negedge clk);
        mode <= 8'h11;
        setting <= 16'h0006;
        run <= 8'h01;
        go <= 1'b1;
        wait_flag();
        check(cap, 32'(6 * LO));
        check(cyc, 32'(6 * LO + 5 * HI + 1));
        check(edg, 32'h0000_0000);
        check(ccnt, 32'h0000_0000);
        clr <= 8'h01;
        @(negedge clk);
        clr <= 8'h00;
        run <= 8'h00;
        go <= 1'b0;
        check(32'(flags[0]), 32'h0000_0000);
    endtask
    // divide by ten, then each enable bit off alone
    task automatic t_presc();
        logic [7:0] offs [2];
        offs = '{8'h40, 8'h01};
        ratio <= 16'h0009;
        mode <= 8'h0A;
        setting <= 16'h0000;
        repeat (2) @(negedge clk);
        run <= 8'h01;
        repeat (101) @(negedge clk);
        check(lvl, 32'h0000_000A);
        check(32'(flags[0]), 32'h0000_0000);
        for (int i = 0; i < 2; i++)
        begin
            run <= 8'h00;
            @(negedge clk);
            unit_en <= offs[i];
            run <= 8'h01;
            repeat (30) @(negedge clk);
            check(lvl, 32'h0000_0000);
        end
    endtask
    // clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            failures++;
            report_and_stop();
        end
    end
    // reset, then the scenarios
    initial
    begin
        rst = 1'b1;
        go = 1'b0;
        idle_lvl = 1'b0;
        unit_en = 8'h41;
        ratio = 16'h0000;
        mode = 8'h00;
        setting = 16'h0000;
        irq_en = 8'h01;
        run = 8'h00;
        clr = 8'h00;
        repeat (2) @(negedge clk);
        rst <= 1'b0;
        t_high_low();
        t_pwm();
        t_presc();
        report_and_stop();
    end
endmodule
